// ==== logic/mxoc_regs.vh ====
`ifndef MXOC_REGS_VH
`define MXOC_REGS_VH
// Contract
// (RULE1) Three 8-bit fill colour registers at 03, 04, 05: red, green, blue.
// (RULE2) Overlay latency 14 cycles when output control bit 7 low, else 12.
// (RULE3) Alpha table bit 5 low: 9-bit alpha direct; high: table lookup.
// (RULE4) Bypass bit 4 high passes pixels unmodified; low: mix only if pin high.
// (RULE5) In bypass, output control bit 3 picks channel: low A, high B.
// (RULE6) Output control bit 2 enables mixed output drivers; low high-impedance.
// (RULE7) Output control bit 1 inverts output bits 15 and 7.
// (RULE8) Sync/blank delay 15 clocks when converter bit 5 low, 2 when high.
// (RULE9) Converter bit 4 inverts chroma MSBs for the converters; the code does so only while converter bit 0 is low.
// (RULE10) Converter bit 3 enables converters; low powers them down.
// (RULE11) Converter bit 2 selects 7.5 IRE blanking setup, else 0 IRE.
// (RULE12) Converter bit 0 converts converter data from YCbCr to GBR.
// (RULE13) Read-only revision at 08 and chip type at 09.
// (RULE14) Crosspoint codes can feed the mixer from the fill registers.
// (RULE15) Two-bit converter source picks A, B or mixed; fourth code reserved.

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define MXOC_ADDR_RED      4'h3
`define MXOC_ADDR_GRN      4'h4
`define MXOC_ADDR_BLU      4'h5
`define MXOC_ADDR_OUTCTL   4'h6
`define MXOC_ADDR_DACCTL   4'h7
`define MXOC_ADDR_REV      4'h8
`define MXOC_ADDR_TYPE     4'h9

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MXOC_OC_LAT        7
`define MXOC_OC_ALUT       5
`define MXOC_OC_PASS       4
`define MXOC_OC_ABSEL      3
`define MXOC_OC_MOUT       2
`define MXOC_OC_MMSB       1
`define MXOC_OC_FMT        0
`define MXOC_DC_DLY        5
`define MXOC_DC_FMT        4
`define MXOC_DC_AWAKE      3
`define MXOC_DC_SETUP      2
`define MXOC_DC_MAT        0

// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define MXOC_RST_BYTE      8'h00
`define MXOC_OC_RDMASK     8'hDF
`define MXOC_DC_WRMASK     8'h3D
// Arbitrary neutral identity values
`define MXOC_REV_CODE      8'h01
`define MXOC_TYPE_CODE     8'h5A

// ----------------------------------------
// Pipeline counts
// ----------------------------------------
`define MXOC_LAT_LONG      14
`define MXOC_LAT_SHORT     12
`define MXOC_SB_LONG       15
`define MXOC_SB_SHORT      2
`endif

// ==== logic/mxoc_delay.v ====
`include "mxoc_regs.vh"
// ----------------------------------------
// Selectable-length delay line
// ----------------------------------------
module mxoc_delay #(
   parameter W     = 1,
   parameter LONG  = 15,
   parameter SHORT = 2
) (
   input  wire         clk_sys,
   input  wire         srst,
   input  wire         sel_short,
   input  wire [W-1:0] din,
   output wire [W-1:0] dout
);
   reg [W-1:0] stage_r [0:LONG-1];
   genvar i;
   generate
      for (i = 0; i < LONG; i = i + 1) begin : g_stage
         always @(posedge clk_sys) begin
            if (srst)
               stage_r[i] <= {W{1'b0}};
            else if (i == 0)
               stage_r[i] <= din;
            else
               stage_r[i] <= stage_r[(i == 0) ? 0 : i - 1];
         end
      end
   endgenerate
   assign dout = sel_short ? stage_r[SHORT-1] : stage_r[LONG-1];
endmodule

// ==== logic/mxoc_csc.v ====
`include "mxoc_regs.vh"
// ----------------------------------------
// YCbCr to GBR, offset-binary chroma
// ----------------------------------------
module mxoc_csc (
   input  wire        clk_sys,
   input  wire        srst,
   input  wire [23:0] ycc,
   output reg  [23:0] gbr
);
   // Shift-add BT.601 approximation keeps it multiplier free
   // Y in the top byte, Cb and Cr below, as on the mixed port
   wire signed [10:0] y  = {3'b000, ycc[23:16]};
   wire signed [10:0] cb = {3'b000, ycc[15:8]} - 11'sd128;
   wire signed [10:0] cr = {3'b000, ycc[7:0]} - 11'sd128;
   wire signed [10:0] r  = y + cr + (cr >>> 1) - (cr >>> 3);
   wire signed [10:0] g  = y - (cb >>> 2) - (cr >>> 1) - (cr >>> 3);
   wire signed [10:0] b  = y + cb + (cb >>> 1) + (cb >>> 2);

   function [7:0] clip;
      input signed [10:0] v;
      begin
         if (v < 0)
            clip = 8'h00;
         else if (v > 255)
            clip = 8'hFF;
         else
            clip = v[7:0];
      end
   endfunction

   always @(posedge clk_sys) begin
      if (srst)
         gbr <= 24'h000000;
      else
         gbr <= {clip(g), clip(b), clip(r)};
   end
endmodule

// ==== logic/mxoc_top.v ====
`include "mxoc_regs.vh"
module mxoc_top (
   input  wire        clk_sys,
   input  wire        srst,
   // Microprocessor port, asynchronous pins
   input  wire        cs_n,
   input  wire        wr_n,
   input  wire [3:0]  addr,
   input  wire [7:0]  data_in,
   output reg  [7:0]  data_out,
   output reg         data_oe,
   // Pixel path
   input  wire [23:0] channel_a_pixels,
   input  wire [23:0] channel_b_pixels,
   input  wire [2:0]  crosspoint_select,
   input  wire [1:0]  converter_source_select,
   input  wire [8:0]  alpha_in,
   input  wire        bypass_enable_pin,
   input  wire [7:0]  overlay_in,
   input  wire        sync_n_in,
   input  wire        blank_n_in,
   output reg  [7:0]  overlay_out,
   output reg  [23:0] mix_out,
   output reg  [23:0] mix_oe,
   output reg         output_packing_format,
   output reg  [23:0] conv_data,
   output reg         conv_sync_n,
   output reg         conv_blank_n,
   output reg         conv_awake,
   output reg         conv_setup
);
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   reg        cs_s1_r;
   reg        cs_s2_r;
   reg        wr_s1_r;
   reg        wr_s2_r;
   reg [3:0]  addr_s1_r;
   reg [3:0]  addr_s2_r;
   reg [7:0]  din_s1_r;
   reg [7:0]  din_s2_r;
   reg        cs_d_r;

   always @(posedge clk_sys) begin
      if (srst) begin
         cs_s1_r   <= 1'b1;
         cs_s2_r   <= 1'b1;
         wr_s1_r   <= 1'b1;
         wr_s2_r   <= 1'b1;
         addr_s1_r <= 4'h0;
         addr_s2_r <= 4'h0;
         din_s1_r  <= 8'h00;
         din_s2_r  <= 8'h00;
         cs_d_r    <= 1'b1;
      end else begin
         cs_s1_r   <= cs_n;
         cs_s2_r   <= cs_s1_r;
         wr_s1_r   <= wr_n;
         wr_s2_r   <= wr_s1_r;
         addr_s1_r <= addr;
         addr_s2_r <= addr_s1_r;
         din_s1_r  <= data_in;
         din_s2_r  <= din_s1_r;
         cs_d_r    <= cs_s2_r;
      end
   end

   // Write commits on rising select, after data has settled
   wire wr_stb = ~cs_d_r & cs_s2_r & ~wr_s2_r;
   wire rd_act = ~cs_s2_r & wr_s2_r;

   // ----------------------------------------
   // Register file
   // ----------------------------------------
   reg [7:0] fill_red_value_r;
   reg [7:0] fill_green_value_r;
   reg [7:0] fill_blue_value_r;
   reg [7:0] output_control_r;
   reg [7:0] converter_control_r;
   reg [7:0] rd_nxt;

   always @(posedge clk_sys) begin
      if (srst) begin
         fill_red_value_r    <= `MXOC_RST_BYTE;
         fill_green_value_r  <= `MXOC_RST_BYTE;
         fill_blue_value_r   <= `MXOC_RST_BYTE;
         output_control_r    <= `MXOC_RST_BYTE;
         converter_control_r <= `MXOC_RST_BYTE;
      end else if (wr_stb) begin
         case (addr_s2_r)
            // (RULE1) fill colour writes
            `MXOC_ADDR_RED:    fill_red_value_r   <= din_s2_r;
            `MXOC_ADDR_GRN:    fill_green_value_r <= din_s2_r;
            `MXOC_ADDR_BLU:    fill_blue_value_r  <= din_s2_r;
            `MXOC_ADDR_OUTCTL: output_control_r   <= din_s2_r;
            `MXOC_ADDR_DACCTL:
               converter_control_r <= din_s2_r & `MXOC_DC_WRMASK;
            default: ;
         endcase
      end
   end

   always @* begin
      case (addr_s2_r)
         `MXOC_ADDR_RED:    rd_nxt = fill_red_value_r;
         `MXOC_ADDR_GRN:    rd_nxt = fill_green_value_r;
         `MXOC_ADDR_BLU:    rd_nxt = fill_blue_value_r;
         // Table enable is write only, reads zero
         `MXOC_ADDR_OUTCTL: rd_nxt = output_control_r & `MXOC_OC_RDMASK;
         `MXOC_ADDR_DACCTL: rd_nxt = converter_control_r;
         // (RULE13) identification readback
         `MXOC_ADDR_REV:    rd_nxt = `MXOC_REV_CODE;
         `MXOC_ADDR_TYPE:   rd_nxt = `MXOC_TYPE_CODE;
         default:           rd_nxt = 8'h00;
      endcase
   end

   always @(posedge clk_sys) begin
      if (srst) begin
         data_out <= 8'h00;
         data_oe  <= 1'b0;
      end else begin
         data_out <= rd_act ? rd_nxt : 8'h00;
         data_oe  <= rd_act;
      end
   end

   wire oc_lat   = output_control_r[`MXOC_OC_LAT];
   wire oc_alut  = output_control_r[`MXOC_OC_ALUT];
   wire oc_pass  = output_control_r[`MXOC_OC_PASS];
   wire oc_absel = output_control_r[`MXOC_OC_ABSEL];
   wire oc_mout  = output_control_r[`MXOC_OC_MOUT];
   wire oc_mmsb  = output_control_r[`MXOC_OC_MMSB];
   wire dc_dly   = converter_control_r[`MXOC_DC_DLY];
   wire dc_fmt   = converter_control_r[`MXOC_DC_FMT];
   wire dc_mat   = converter_control_r[`MXOC_DC_MAT];

   // ----------------------------------------
   // Alpha table
   // ----------------------------------------
   // Table contents are not loadable here; identity ramp plus unity code
   reg [8:0] alpha_table [0:255];
   reg [8:0] alpha_r;
   integer k;
   always @(posedge clk_sys) begin
      if (srst) begin
         for (k = 0; k < 256; k = k + 1)
            alpha_table[k] <= (k == 255) ? 9'h100 : k[8:0];
      end
   end

   always @(posedge clk_sys) begin
      if (srst)
         alpha_r <= 9'h000;
      // (RULE3) table or direct alpha
      else if (oc_alut)
         alpha_r <= alpha_table[alpha_in[7:0]];
      else
         alpha_r <= alpha_in;
   end

   // ----------------------------------------
   // Crosspoint and mixer
   // ----------------------------------------
   // Port order is G/Y, B/Cb, R/Cr from the top byte down
   wire [23:0] fill_pix = {fill_green_value_r, fill_blue_value_r,
                           fill_red_value_r};
   reg  [23:0] v1_r;
   reg  [23:0] v2_r;
   reg  [23:0] mixed_r;
   reg  [23:0] mix_nxt;
   reg  [23:0] mix_pre_r;

   always @(posedge clk_sys) begin
      if (srst) begin
         v1_r <= 24'h000000;
         v2_r <= 24'h000000;
      end else begin
         // (RULE14) fill source on crosspoint
         case (crosspoint_select)
            3'h0: begin v1_r <= channel_a_pixels; v2_r <= channel_b_pixels; end
            3'h1: begin v1_r <= channel_a_pixels; v2_r <= fill_pix; end
            3'h2: begin v1_r <= channel_b_pixels; v2_r <= channel_a_pixels; end
            3'h3: begin v1_r <= channel_b_pixels; v2_r <= fill_pix; end
            3'h4: begin v1_r <= fill_pix; v2_r <= channel_a_pixels; end
            3'h5: begin v1_r <= fill_pix; v2_r <= channel_b_pixels; end
            default: begin v1_r <= channel_a_pixels; v2_r <= channel_b_pixels; end
         endcase
      end
   end

   // Per-component (v1 - v2) * alpha / 256 + v2
   genvar c;
   generate
      for (c = 0; c < 3; c = c + 1) begin : g_mix
         wire [7:0]  p1 = v1_r[c*8+7:c*8];
         wire [7:0]  p2 = v2_r[c*8+7:c*8];
         wire [17:0] prod = ({10'h000, p1} * {9'h000, alpha_r})
                          + ({10'h000, p2} * ({9'h000, 9'h100} - {9'h000, alpha_r}));
         always @(posedge clk_sys) begin
            if (srst)
               mixed_r[c*8+7:c*8] <= 8'h00;
            else
               mixed_r[c*8+7:c*8] <= prod[15:8];
         end
      end
   endgenerate

   reg        pin_s1_r;
   reg        pin_s2_r;
   reg [23:0] a_d1_r;
   reg [23:0] b_d1_r;
   reg [23:0] a_d2_r;
   reg [23:0] b_d2_r;
   always @(posedge clk_sys) begin
      if (srst) begin
         pin_s1_r <= 1'b0;
         pin_s2_r <= 1'b0;
         a_d1_r   <= 24'h000000;
         b_d1_r   <= 24'h000000;
         a_d2_r   <= 24'h000000;
         b_d2_r   <= 24'h000000;
      end else begin
         pin_s1_r <= bypass_enable_pin;
         pin_s2_r <= pin_s1_r;
         a_d1_r   <= channel_a_pixels;
         b_d1_r   <= channel_b_pixels;
         a_d2_r   <= a_d1_r;
         b_d2_r   <= b_d1_r;
      end
   end

   always @* begin
      // (RULE4) bypass or gated mixing
      if (oc_pass | ~pin_s2_r)
         // (RULE5) channel choice in bypass
         mix_nxt = oc_absel ? b_d2_r : a_d2_r;
      else
         mix_nxt = mixed_r;
   end

   always @(posedge clk_sys) begin
      if (srst) begin
         mix_pre_r             <= 24'h000000;
         mix_out               <= 24'h000000;
         mix_oe                <= 24'h000000;
         output_packing_format <= 1'b0;
      end else begin
         mix_pre_r <= mix_nxt;
         // (RULE7) invert output chroma MSBs
         mix_out <= mix_pre_r ^ {8'h00, oc_mmsb, 7'h00, oc_mmsb, 7'h00};
         // (RULE6) output driver enable
         mix_oe  <= {24{oc_mout}};
         output_packing_format <= output_control_r[`MXOC_OC_FMT];
      end
   end

   // ----------------------------------------
   // Overlay pipe
   // ----------------------------------------
   wire [7:0] ovl_dly;
   // (RULE2) overlay latency select
   mxoc_delay #(
      .W     (8),
      .LONG  (`MXOC_LAT_LONG - 1),
      .SHORT (`MXOC_LAT_SHORT - 1)
   ) u_ovl (
      .clk_sys   (clk_sys),
      .srst      (srst),
      .sel_short (oc_lat),
      .din       (overlay_in),
      .dout      (ovl_dly)
   );

   // ----------------------------------------
   // Converter path
   // ----------------------------------------
   reg  [23:0] conv_src_r;
   wire [23:0] conv_gbr;
   wire [1:0]  sb_dly;
   always @(posedge clk_sys) begin
      if (srst)
         conv_src_r <= 24'h000000;
      else begin
         // (RULE15) converter source choice
         case (converter_source_select)
            2'h0:    conv_src_r <= a_d1_r;
            2'h1:    conv_src_r <= b_d1_r;
            2'h2:    conv_src_r <= mix_pre_r;
            default: conv_src_r <= 24'h000000;
         endcase
      end
   end

   mxoc_csc u_csc (
      .clk_sys (clk_sys),
      .srst    (srst),
      .ycc     (conv_src_r),
      .gbr     (conv_gbr)
   );

   // Active-high copies, so the zero reset flush reads as idle
   // (RULE8) sync and blank delay
   mxoc_delay #(
      .W     (2),
      .LONG  (`MXOC_SB_LONG - 1),
      .SHORT (`MXOC_SB_SHORT - 1)
   ) u_sb (
      .clk_sys   (clk_sys),
      .srst      (srst),
      .sel_short (dc_dly),
      .din       ({~sync_n_in, ~blank_n_in}),
      .dout      (sb_dly)
   );

   always @(posedge clk_sys) begin
      if (srst) begin
         overlay_out  <= 8'h00;
         conv_data    <= 24'h000000;
         conv_sync_n  <= 1'b1;
         conv_blank_n <= 1'b1;
         conv_awake   <= 1'b0;
         conv_setup   <= 1'b0;
      end else begin
         overlay_out  <= ovl_dly;
         // (RULE12) matrix, (RULE9) chroma offset
         conv_data    <= dc_mat ? conv_gbr :
                         conv_src_r ^ {8'h00, dc_fmt, 7'h00, dc_fmt, 7'h00};
         conv_sync_n  <= ~sb_dly[1];
         conv_blank_n <= ~sb_dly[0];
         // (RULE10) converter power
         conv_awake   <= converter_control_r[`MXOC_DC_AWAKE];
         // (RULE11) blanking setup level
         conv_setup   <= converter_control_r[`MXOC_DC_SETUP];
      end
   end
endmodule

// ==== test/mxoc_checker.sv ====
// ----------------------------------------
// Port checker
// ----------------------------------------
module mxoc_checker (
   input wire logic        clk_sys,
   input wire logic        srst,
   input wire logic        cs_n,
   input wire logic        wr_n,
   input wire logic        data_oe,
   input wire logic [7:0]  overlay_in,
   input wire logic [7:0]  overlay_out,
   input wire logic        sync_n_in,
   input wire logic        blank_n_in,
   input wire logic        conv_sync_n,
   input wire logic        conv_blank_n,
   input wire logic [23:0] mix_oe,
   input wire logic        conv_awake,
   input wire logic        conv_setup,
   input wire logic        output_packing_format
);
   timeunit 1ns;
   timeprecision 1ns;

   // Pipes judged only once bus and reset are long quiet
   logic [4:0] calm_r;
   always_ff @(posedge clk_sys) begin
      if (srst || !cs_n)
         calm_r <= 5'h00;
      else if (calm_r != 5'h1F)
         calm_r <= calm_r + 5'h01;
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);

   a_ovl_latency: assert property (
      calm_r == 5'h1F |-> overlay_out == $past(overlay_in, 14)
                       || overlay_out == $past(overlay_in, 12))
      else $error("overlay latency neither 14 nor 12");
   a_sync_delay: assert property (
      calm_r == 5'h1F |-> conv_sync_n == $past(sync_n_in, 15)
                       || conv_sync_n == $past(sync_n_in, 2))
      else $error("sync delay neither 15 nor 2");
   a_blank_delay: assert property (
      calm_r == 5'h1F |-> conv_blank_n == $past(blank_n_in, 15)
                       || conv_blank_n == $past(blank_n_in, 2))
      else $error("blank delay neither 15 nor 2");
   a_read_answer: assert property (
      $fell(cs_n) && wr_n |-> ##[1:5] data_oe)
      else $error("read data not driven in time");
   a_read_hold: assert property (
      data_oe && !cs_n |=> data_oe)
      else $error("read data dropped while selected");
   a_read_release: assert property (
      $rose(cs_n) |-> ##[1:5] !data_oe)
      else $error("read data not released");
   a_idle_quiet: assert property (
      cs_n [*6] |-> !data_oe)
      else $error("data bus driven while idle");
   a_oe_uniform: assert property (
      mix_oe == {24{mix_oe[0]}})
      else $error("output enables disagree");
   a_ctl_cause: assert property (
      $changed(conv_awake) || $changed(conv_setup) || $changed(mix_oe)
      || $changed(output_packing_format) |-> !$past(wr_n) || !$past(wr_n, 2))
      else $error("control output moved without a write");

   c_read: cover property ($fell(cs_n) && wr_n);
   c_write: cover property ($rose(cs_n) && !wr_n);
   c_awake: cover property ($rose(conv_awake));
endmodule

bind mxoc_top mxoc_checker mxoc_checker_i (
   .clk_sys(clk_sys), .srst(srst), .cs_n(cs_n), .wr_n(wr_n),
   .data_oe(data_oe), .overlay_in(overlay_in), .overlay_out(overlay_out),
   .sync_n_in(sync_n_in), .blank_n_in(blank_n_in),
   .conv_sync_n(conv_sync_n), .conv_blank_n(conv_blank_n),
   .mix_oe(mix_oe), .conv_awake(conv_awake), .conv_setup(conv_setup),
   .output_packing_format(output_packing_format));

// ==== test/mxoc_tb_top.sv ====
module mxoc_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
`include "mxoc_regs.vh"
   logic        clk_sys = 1'b0;
   logic        srst = 1'b1;
   logic        cs_n = 1'b1;
   logic        wr_n = 1'b1;
   logic [3:0]  addr = 4'h0;
   logic [7:0]  data_in = 8'h00;
   logic [23:0] channel_a_pixels = 24'h123456;
   logic [23:0] channel_b_pixels = 24'h89ABCD;
   logic [2:0]  crosspoint_select = 3'h0;
   logic [1:0]  converter_source_select = 2'h0;
   logic [8:0]  alpha_in = 9'h000;
   logic        bypass_enable_pin = 1'b0;
   logic [7:0]  overlay_in = 8'h00;
   logic        sync_n_in = 1'b1;
   logic        blank_n_in = 1'b1;
   logic [7:0]  data_out, overlay_out;
   logic        data_oe, output_packing_format, conv_sync_n, conv_blank_n;
   logic        conv_awake, conv_setup;
   logic [23:0] mix_out, mix_oe, conv_data;
   int          bad_count = 0;
   int          samples_checked = 0;

   mxoc_top mxoc_top_i (.clk_sys, .srst, .cs_n, .wr_n, .addr, .data_in,
      .data_out, .data_oe, .channel_a_pixels, .channel_b_pixels,
      .crosspoint_select, .converter_source_select, .alpha_in,
      .bypass_enable_pin, .overlay_in, .sync_n_in, .blank_n_in,
      .overlay_out, .mix_out, .mix_oe, .output_packing_format, .conv_data,
      .conv_sync_n, .conv_blank_n, .conv_awake, .conv_setup);

   initial forever #20 clk_sys = ~clk_sys;

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string what, input logic [23:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // Address, data and write level held past the late commit
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      tick(1);
      addr <= a;
      data_in <= d;
      wr_n <= 1'b0;
      tick(1);
      cs_n <= 1'b0;
      tick(4);
      cs_n <= 1'b1;
      tick(7);
      wr_n <= 1'b1;
      tick(5);
   endtask

   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      int k;
      addr <= a;
      cs_n <= 1'b0;
      k = 0;
      while (data_oe !== 1'b1 && k < 10) begin
         tick(1);
         k++;
      end
      if (k == 10) begin
         bad_count++;
         give_verdict;
      end
      tick(1);
      d = data_out;
      cs_n <= 1'b1;
      tick(6);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs;
      logic [3:0] ad [7] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hA};
      logic [7:0] ex [7] = '{8'hA5, 8'h5A, 8'h3C, 8'hDF, 8'h3D,
                             `MXOC_REV_CODE, 8'h00};
      logic [7:0] d, e;
      for (int a = 3; a < 11; a++) begin
         rd(a[3:0], d);
         e = a == 8 ? `MXOC_REV_CODE : a == 9 ? `MXOC_TYPE_CODE : 8'h00;
         chk("reset read", {16'h0000, d}, {16'h0000, e});
      end
      foreach (ad[i]) wr(ad[i], i < 3 ? ex[i] : 8'hFF);
      foreach (ad[i]) begin
         rd(ad[i], d);
         chk("readback", {16'h0000, d}, {16'h0000, ex[i]});
      end
      $display("register test done");
   endtask

   task automatic t_lat(input logic s);
      int no, ns, nb;
      wr(4'h6, {s, 7'h00});
      wr(4'h7, {2'b00, s, 5'h00});
      tick(30);
      overlay_in <= 8'hA5;
      sync_n_in <= 1'b0;
      blank_n_in <= 1'b0;
      tick(1);
      overlay_in <= 8'h00;
      sync_n_in <= 1'b1;
      blank_n_in <= 1'b1;
      no = 0;
      ns = 0;
      nb = 0;
      for (int n = 1; n < 20; n++) begin
         #1;
         if (overlay_out === 8'hA5 && no == 0) no = n;
         if (conv_sync_n === 1'b0 && ns == 0) ns = n;
         if (conv_blank_n === 1'b0 && nb == 0) nb = n;
         tick(1);
      end
      chk("overlay latency", 24'(no), s ? 24'd12 : 24'd14);
      chk("sync delay", 24'(ns), s ? 24'd2 : 24'd15);
      chk("blank delay", 24'(nb), s ? 24'd2 : 24'd15);
      $display("latency test done");
   endtask

   task automatic t_mix;
      logic [7:0]  oc [5] = '{8'h14, 8'h1C, 8'h1E, 8'h19, 8'h04};
      logic [23:0] em [5] = '{24'h123456, 24'h89ABCD, 24'h892B4D,
                              24'h000000, 24'h123456};
      logic [2:0]  xs [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h5};
      logic [23:0] ev [6] = '{24'h89ABCD, 24'h223311, 24'h123456,
                              24'h223311, 24'h89ABCD, 24'h89ABCD};
      foreach (oc[i]) begin
         wr(4'h6, oc[i]);
         tick(6);
         #1;
         chk("drive enable", mix_oe, {24{oc[i][2]}});
         chk("packing", 24'(output_packing_format), 24'(oc[i][0]));
         if (oc[i][2]) chk("bypass", mix_out, em[i]);
      end
      wr(4'h3, 8'h11);
      wr(4'h4, 8'h22);
      wr(4'h5, 8'h33);
      bypass_enable_pin <= 1'b1;
      crosspoint_select <= 3'h4;
      alpha_in <= 9'h100;
      wr(4'h6, 8'h04);
      tick(8);
      #1;
      chk("fill mix", mix_out, 24'h223311);
      tick(1);
      alpha_in <= 9'h000;
      tick(8);
      #1;
      chk("zero alpha", mix_out, 24'h123456);
      foreach (xs[i]) begin
         tick(1);
         crosspoint_select <= xs[i];
         tick(8);
         #1;
         chk("crosspoint", mix_out, ev[i]);
      end
      wr(4'h6, 8'h24);
      alpha_in <= 9'h0FF;
      tick(8);
      #1;
      chk("table alpha", mix_out, 24'h223311);
      $display("mixer test done");
   endtask

   task automatic t_conv;
      logic [1:0]  sr [5] = '{2'h0, 2'h1, 2'h0, 2'h2, 2'h3};
      logic [7:0]  dc [5] = '{8'h08, 8'h0C, 8'h18, 8'h08, 8'h00};
      logic [23:0] ed [5] = '{24'h123456, 24'h89ABCD, 24'h12B4D6,
                              24'h223311, 24'h000000};
      foreach (sr[i]) begin
         wr(4'h7, dc[i]);
         converter_source_select <= sr[i];
         tick(20);
         #1;
         chk("conv data", conv_data, ed[i]);
         chk("awake", 24'(conv_awake), 24'(dc[i][3]));
         chk("setup", 24'(conv_setup), 24'(dc[i][2]));
      end
      wr(4'h7, 8'h19);
      channel_a_pixels <= 24'h508080;
      converter_source_select <= 2'h0;
      tick(20);
      #1;
      chk("matrix", conv_data, 24'h505050);
      $display("converter test done");
   endtask

   initial begin
      tick(3);
      srst <= 1'b0;
      tick(2);
      t_regs;
      t_lat(1'b0);
      t_lat(1'b1);
      t_mix;
      t_conv;
      give_verdict;
   end
endmodule
